// file: logic/fpsc_top.v
// Fan drive register set, spin-up sequencer and open-drain output
`include "fpsc_defines.vh"

module fpsc_top #(
    parameter SPINUP_UNIT_CYCLES = (`FPSC_CLK_HZ / 1000) * `FPSC_SPINUP_UNIT_MS,  // Cycles per 0.05 s
    parameter SLOW_DIV_CYCLES    = `FPSC_CLK_HZ / `FPSC_BASE_SLOW_HZ               // Cycles per slow tick
) (
    input  wire       CLOCK_IN,             // 40 MHz system clock
    input  wire       RESETN_IN,            // Synchronous reset, active low
    input  wire [7:0] REG_ADDR_IN,          // Register offset
    input  wire       REG_WR_IN,            // Write strobe, one cycle
    input  wire       REG_RD_IN,            // Read strobe, one cycle
    input  wire [7:0] REG_WDATA_IN,         // Write data
    output wire [7:0] REG_RDATA_OUT,        // Read data, registered
    input  wire       MANUAL_DRIVE_IN,      // Host owns the drive level
    input  wire       SLOW_CLOCK_SEL_IN,    // Base clock select
    input  wire [5:0] TABLE_LEVEL_IN,       // Level from the lookup table
    input  wire       TACH_AT_SPEED_IN,     // Tach measure reached target speed
    output wire       FAN_PWM_OUT,          // Open-drain pin output value
    output wire       FAN_PWM_OE_OUT,       // Open-drain enable, high pulls low
    output wire       SPINUP_ACTIVE_OUT     // Spin-up in progress
);

    localparam FAST_DIV_CYCLES = `FPSC_CLK_HZ / `FPSC_BASE_FAST_HZ;
    localparam ST_IDLE         = 1'b0;
    localparam ST_SPIN         = 1'b1;

    reg  [5:0]  startup_q;
    reg  [5:0]  level_q;
    reg  [4:0]  divisor_q;
    reg  [7:0]  rdata_q;
    reg         state_q;
    reg         state_d;
    reg  [31:0] spin_cnt_q;
    reg  [31:0] spin_cnt_d;
    reg  [31:0] spin_limit_q;
    reg  [5:0]  spin_level_q;
    reg         spin_fast_q;
    reg         want_prev_q;
    reg         oe_q;
    reg  [7:0]  rdata_d;
    wire        fast_sel;
    wire [1:0]  duty_code;
    wire [2:0]  time_code;
    wire [5:0]  req_level;
    wire        want_on;
    wire        start_req;
    wire        bypass;
    wire [5:0]  drive_level;
    wire        fan_on;
    wire        wr_level;

    // Startup duty decode
    function [5:0] duty_level;
        input [1:0] code;
        input       fast;
        begin
            if (fast)
                duty_level = `FPSC_LEVEL_FULL;
            else begin
                case (code)
                    `FPSC_DUTY_HALF: duty_level = `FPSC_LEVEL_HALF;
                    `FPSC_DUTY_3Q:   duty_level = `FPSC_LEVEL_3Q;
                    `FPSC_DUTY_FULL: duty_level = `FPSC_LEVEL_FULL;
                    default:         duty_level = 6'h00;
                endcase
            end
        end
    endfunction

    // Startup duration decode, doubling per code step
    function [31:0] spin_cycles;
        input [2:0] code;
        reg   [31:0] unit;
        begin
            unit        = SPINUP_UNIT_CYCLES;
            spin_cycles = (code == 3'h0) ? 32'h0 : (unit << (code - 3'h1));
        end
    endfunction

    // Field extraction
    assign fast_sel  = startup_q[`FPSC_SU_FAST_BIT];
    assign duty_code = startup_q[`FPSC_SU_DUTY_HI:`FPSC_SU_DUTY_LO];
    assign time_code = startup_q[`FPSC_SU_TIME_HI:`FPSC_SU_TIME_LO];

    // Requested level: lookup table or host value
    assign req_level = MANUAL_DRIVE_IN ? level_q : TABLE_LEVEL_IN;
    assign want_on   = (req_level != 6'h00);
    assign start_req = want_on & ~want_prev_q;

    // Spin-up skipped on zero duration, or zero duty when not fast
    assign bypass = (time_code == 3'h0)
                  | ((duty_code == `FPSC_DUTY_OFF) & ~fast_sel);

    // Level reaching the waveform generator
    assign drive_level = (state_q == ST_SPIN) ? spin_level_q : req_level;

    assign wr_level = REG_WR_IN & (REG_ADDR_IN == `FPSC_ADDR_LEVEL);

    // Register writes
    always @(posedge CLOCK_IN) begin
        if (!RESETN_IN) begin
            startup_q <= `FPSC_RST_STARTUP;
            divisor_q <= `FPSC_RST_DIVISOR;
            level_q   <= `FPSC_RST_LEVEL;
        end else begin
            if (REG_WR_IN && REG_ADDR_IN == `FPSC_ADDR_STARTUP)
                startup_q <= REG_WDATA_IN[5:0];
            if (REG_WR_IN && REG_ADDR_IN == `FPSC_ADDR_DIVISOR)
                divisor_q <= REG_WDATA_IN[4:0];
            if (!MANUAL_DRIVE_IN)
                level_q <= TABLE_LEVEL_IN;
            else if (wr_level)
                level_q <= REG_WDATA_IN[5:0];
        end
    end

    // Spin-up sequencer next state
    always @* begin
        state_d    = state_q;
        spin_cnt_d = spin_cnt_q;
        case (state_q)
            ST_IDLE: begin
                spin_cnt_d = 32'h0;
                if (start_req && !bypass)
                    state_d = ST_SPIN;
            end
            ST_SPIN: begin
                spin_cnt_d = spin_cnt_q + 32'h1;
                if (!want_on)
                    state_d = ST_IDLE;
                else if (spin_cnt_q + 32'h1 >= spin_limit_q)
                    state_d = ST_IDLE;
                else if (spin_fast_q && TACH_AT_SPEED_IN)
                    state_d = ST_IDLE;
            end
            default: begin
                state_d    = ST_IDLE;
                spin_cnt_d = 32'h0;
            end
        endcase
    end

    // Spin-up sequencer registers; duty and time captured at start
    always @(posedge CLOCK_IN) begin
        if (!RESETN_IN) begin
            state_q      <= ST_IDLE;
            spin_cnt_q   <= 32'h0;
            spin_limit_q <= 32'h0;
            spin_level_q <= 6'h00;
            spin_fast_q  <= 1'b0;
            want_prev_q  <= 1'b0;
        end else begin
            state_q     <= state_d;
            spin_cnt_q  <= spin_cnt_d;
            want_prev_q <= want_on;
            if (state_q == ST_IDLE && start_req) begin
                spin_limit_q <= spin_cycles(time_code);
                spin_level_q <= duty_level(duty_code, fast_sel);
                spin_fast_q  <= fast_sel;
            end
        end
    end

    // Read data mux
    always @* begin
        case (REG_ADDR_IN)
            `FPSC_ADDR_STARTUP: rdata_d = {2'h0, startup_q};
            `FPSC_ADDR_LEVEL:   rdata_d = (state_q == ST_SPIN) ? 8'h00 : {2'h0, level_q};
            `FPSC_ADDR_DIVISOR: rdata_d = {3'h0, divisor_q};
            default:            rdata_d = 8'h00;
        endcase
    end

    // Read data register
    always @(posedge CLOCK_IN) begin
        if (!RESETN_IN)
            rdata_q <= 8'h00;
        else if (REG_RD_IN)
            rdata_q <= rdata_d;
    end

    // Waveform generator
    fpsc_pwm_gen #(
        .FAST_DIV (FAST_DIV_CYCLES),
        .SLOW_DIV (SLOW_DIV_CYCLES)
    ) u_pwm (
        .clk_in      (CLOCK_IN),
        .rst_n_in    (RESETN_IN),
        .slow_sel_in (SLOW_CLOCK_SEL_IN),
        .divisor_in  (divisor_q),
        .level_in    (drive_level),
        .fan_on_out  (fan_on)
    );

    // Open-drain pin: pulled low while fan is off
    always @(posedge CLOCK_IN) begin
        if (!RESETN_IN)
            oe_q <= 1'b1;
        else
            oe_q <= ~fan_on;
    end

    assign FAN_PWM_OUT       = 1'b0;
    assign FAN_PWM_OE_OUT    = oe_q;
    assign SPINUP_ACTIVE_OUT = state_q;
    assign REG_RDATA_OUT     = rdata_q;

endmodule

// file: logic/fpsc_defines.vh
// Register map, field layout, reset values and timing figures of the fan drive block
`ifndef FPSC_DEFINES_VH
`define FPSC_DEFINES_VH

// Register offsets
`define FPSC_ADDR_STARTUP      8'h4b
`define FPSC_ADDR_LEVEL        8'h4c
`define FPSC_ADDR_DIVISOR      8'h4d

// Startup configuration fields
`define FPSC_SU_FAST_BIT       5
`define FPSC_SU_DUTY_HI        4
`define FPSC_SU_DUTY_LO        3
`define FPSC_SU_TIME_HI        2
`define FPSC_SU_TIME_LO        0

// Reset values
`define FPSC_RST_STARTUP       6'h3f
`define FPSC_RST_LEVEL         6'h00
`define FPSC_RST_DIVISOR       5'h17

// Startup duty codes
`define FPSC_DUTY_OFF          2'h0
`define FPSC_DUTY_HALF         2'h1
`define FPSC_DUTY_3Q           2'h2
`define FPSC_DUTY_FULL         2'h3

// Drive levels used during spin-up
`define FPSC_LEVEL_HALF        6'h20
`define FPSC_LEVEL_3Q          6'h30
`define FPSC_LEVEL_FULL        6'h3f

// Timing figures
`define FPSC_CLK_HZ            40000000
`define FPSC_BASE_FAST_HZ      360000
`define FPSC_BASE_SLOW_HZ      1400
`define FPSC_SPINUP_UNIT_MS    50

`endif

// file: logic/fpsc_pwm_gen.v
// Base clock divider and fan drive waveform generator
`include "fpsc_defines.vh"

module fpsc_pwm_gen #(
    parameter FAST_DIV = `FPSC_CLK_HZ / `FPSC_BASE_FAST_HZ,   // Clock cycles per fast base tick
    parameter SLOW_DIV = `FPSC_CLK_HZ / `FPSC_BASE_SLOW_HZ    // Clock cycles per slow base tick
) (
    input  wire       clk_in,               // System clock
    input  wire       rst_n_in,             // Synchronous reset, active low
    input  wire       slow_sel_in,          // 1 selects the slow base clock
    input  wire [4:0] divisor_in,           // Output rate divisor n
    input  wire [5:0] level_in,             // Drive level 0..63
    output wire       fan_on_out            // Fan drive active, registered
);

    reg  [14:0] tick_cnt_q;
    reg  [5:0]  phase_q;
    reg  [5:0]  period_q;
    reg  [5:0]  level_q;
    reg         on_q;
    wire [14:0] tick_max;
    wire        tick;
    wire [4:0]  n_eff;
    wire [5:0]  period_d;
    wire [11:0] phase_scaled;
    wire [11:0] on_scaled;

    // Base tick selection
    assign tick_max = slow_sel_in ? SLOW_DIV[14:0] - 15'h0001 : FAST_DIV[14:0] - 15'h0001;
    assign tick     = (tick_cnt_q >= tick_max);

    // Divisor zero acts as one; period is 2n base ticks
    assign n_eff    = (divisor_in == 5'h00) ? 5'h01 : divisor_in;
    assign period_d = {n_eff, 1'b0};

    // Duty compare scaled to 64 steps per period
    assign phase_scaled = {phase_q, 6'h00};
    assign on_scaled    = level_q * period_q;

    // Base divider and phase counter; divisor and level taken at period start, clock select and full level at once
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            tick_cnt_q <= 15'h0000;
            phase_q    <= 6'h00;
            period_q   <= {`FPSC_RST_DIVISOR, 1'b0};
            level_q    <= 6'h00;
            on_q       <= 1'b0;
        end else begin
            if (tick) begin
                tick_cnt_q <= 15'h0000;
                if (phase_q + 6'h01 >= period_q) begin
                    phase_q  <= 6'h00;
                    period_q <= period_d;
                    level_q  <= level_in;
                end else begin
                    phase_q <= phase_q + 6'h01;
                end
            end else begin
                tick_cnt_q <= tick_cnt_q + 15'h0001;
            end
            if (level_in == `FPSC_LEVEL_FULL)
                on_q <= 1'b1;
            else
                on_q <= (level_q == `FPSC_LEVEL_FULL) ? 1'b1 : (phase_scaled < on_scaled);
        end
    end

    assign fan_on_out = on_q;

endmodule

// file: testbench/fpsc_checker.sv
// Port assertions for the fan drive block
module fpsc_checker (
    input wire logic       CLOCK_IN,          // Clock
    input wire logic       RESETN_IN,         // Reset, low
    input wire logic [7:0] REG_ADDR_IN,       // Offset
    input wire logic       REG_WR_IN,         // Write
    input wire logic       REG_RD_IN,         // Read
    input wire logic [7:0] REG_WDATA_IN,      // Write data
    input wire logic [7:0] REG_RDATA_OUT,     // Read data
    input wire logic       TACH_AT_SPEED_IN,  // At speed
    input wire logic       FAN_PWM_OE_OUT,    // Pin pulled low
    input wire logic       SPINUP_ACTIVE_OUT  // Spin-up
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] cfg_q;  // Startup register shadow
    logic       fast_q; // Fast bit as taken at spin-up start
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (!RESETN_IN);
    // Follow host writes to the startup register
    always_ff @(posedge CLOCK_IN) begin
        if (!RESETN_IN) cfg_q <= 6'h3f;
        else if (REG_WR_IN && REG_ADDR_IN == 8'h4b) cfg_q <= REG_WDATA_IN[5:0];
    end
    // Fast bit frozen while a spin-up runs; later writes count for the next one
    always_ff @(posedge CLOCK_IN) begin
        if (!RESETN_IN) fast_q <= 1'b0;
        else if (!SPINUP_ACTIVE_OUT) fast_q <= cfg_q[5];
    end
    chk_spin_read_zero: assert property (REG_RD_IN && REG_ADDR_IN == 8'h4c && SPINUP_ACTIVE_OUT
        |=> REG_RDATA_OUT == 8'h00) else $error("level not zero in spin-up");
    chk_rate_upper: assert property (REG_RD_IN && REG_ADDR_IN == 8'h4d
        |=> REG_RDATA_OUT[7:5] == 3'h0) else $error("divisor upper bits set");
    chk_cfg_upper: assert property (REG_RD_IN && REG_ADDR_IN inside {8'h4b, 8'h4c}
        |=> REG_RDATA_OUT[7:6] == 2'h0) else $error("upper bits set");
    chk_cfg_readback: assert property (REG_RD_IN && REG_ADDR_IN == 8'h4b && !REG_WR_IN
        |=> REG_RDATA_OUT[5:0] == cfg_q) else $error("startup readback");
    chk_time_bypass: assert property ($rose(SPINUP_ACTIVE_OUT) |-> $past(cfg_q[2:0]) != 3'h0)
        else $error("spin-up with time zero");
    chk_duty_bypass: assert property ($rose(SPINUP_ACTIVE_OUT)
        |-> $past(cfg_q[4:3]) != 2'h0 || fast_q) else $error("spin-up with duty zero");
    chk_fast_start: assert property ($rose(SPINUP_ACTIVE_OUT) && fast_q
        |-> ##[1:4] !FAN_PWM_OE_OUT) else $error("fast spin-up not on");
    chk_fast_hold: assert property (SPINUP_ACTIVE_OUT[*5] ##0 fast_q |-> !FAN_PWM_OE_OUT)
        else $error("fast spin-up dropped");
    chk_tach_stop: assert property (SPINUP_ACTIVE_OUT && TACH_AT_SPEED_IN && fast_q
        |-> ##[1:2] !SPINUP_ACTIVE_OUT) else $error("tach did not end spin-up");
    cover property ($fell(SPINUP_ACTIVE_OUT));
    cover property (SPINUP_ACTIVE_OUT && TACH_AT_SPEED_IN);
    cover property (REG_RD_IN && REG_ADDR_IN == 8'h4c && SPINUP_ACTIVE_OUT);
endmodule
bind fpsc_top fpsc_checker fpsc_checker_i (.CLOCK_IN, .RESETN_IN, .REG_ADDR_IN, .REG_WR_IN, .REG_RD_IN,
    .REG_WDATA_IN, .REG_RDATA_OUT, .TACH_AT_SPEED_IN, .FAN_PWM_OE_OUT, .SPINUP_ACTIVE_OUT);

// file: testbench/fpsc_fan_switch.sv
// Fan power switch on the open-drain pin
module fpsc_fan_switch (
    input  wire logic pin_value_in,  // Driven value
    input  wire logic pin_oe_in,     // Pull enable
    output wire logic fan_on_out     // Fan powered
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pull-up holds a released pin high: open means fan on
    assign fan_on_out = pin_oe_in ? pin_value_in : 1'b1;
endmodule

// file: testbench/tb_top.sv
// Self-checking testbench for the fan drive block
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int UNIT = 1000;  // Shortened 0.05 s
    localparam int SLOW = 20;    // Shortened slow tick
    localparam int FAST = 111;   // Fast tick at 40 MHz
    logic       clk = 1'b0, rstn = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
    logic       man = 1'b0, slow = 1'b0, tach = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    logic [5:0] tbl = 6'h00;
    wire  [7:0] rdata;
    wire        pout, oe, spin, fan_on;
    int         fails = 0, checked = 0;
    fpsc_top #(.SPINUP_UNIT_CYCLES(UNIT), .SLOW_DIV_CYCLES(SLOW)) fpsc_top_i (
        .CLOCK_IN(clk), .RESETN_IN(rstn), .REG_ADDR_IN(addr), .REG_WR_IN(wr_s), .REG_RD_IN(rd_s),
        .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .MANUAL_DRIVE_IN(man), .SLOW_CLOCK_SEL_IN(slow),
        .TABLE_LEVEL_IN(tbl), .TACH_AT_SPEED_IN(tach), .FAN_PWM_OUT(pout), .FAN_PWM_OE_OUT(oe),
        .SPINUP_ACTIVE_OUT(spin));
    fpsc_fan_switch fpsc_fan_switch_i (.pin_value_in(pout), .pin_oe_in(oe), .fan_on_out(fan_on));
    // 40 MHz clock
    always #12.5 clk = ~clk;
    task automatic wrap_up();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t ns: saw %0h, wanted %0h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #2;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        tick();
        wr_s = 1'b0;
        tick();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd_s = 1'b1;
        tick();
        rd_s = 1'b0;
        check(rdata, exp);
        tick();
    endtask
    // Cycles until the fan next switches on
    task automatic fall(output int c);
        c = 0;
        while (oe !== 1'b1 && c < 9000) begin tick(); c++; end
        while (oe !== 1'b0 && c < 9000) begin tick(); c++; end
        if (c >= 9000) begin fails++; wrap_up(); end
    endtask
    // Reset values, unused bits, unmapped place, level ownership
    task automatic t_regs();
        rd(8'h4b, 8'h3f);
        rd(8'h4c, 8'h00);
        rd(8'h4d, 8'h17);
        rd(8'h4e, 8'h00);
        wr(8'h4d, 8'hff);
        rd(8'h4d, 8'h1f);
        wr(8'h4b, 8'hc0);
        rd(8'h4b, 8'h00);
        tbl = 6'h15;
        wr(8'h4c, 8'h2a);
        rd(8'h4c, 8'h15);
        man = 1'b1;
        wr(8'h4c, 8'hff);
        rd(8'h4c, 8'h3f);
    endtask
    // Output period over both base clocks and several divisors
    task automatic t_period();
        logic       s [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
        logic [4:0] d [4] = '{5'h00, 5'h01, 5'h03, 5'h02};
        int         c;
        wr(8'h4c, 8'h20);
        for (int i = 0; i < 4; i++) begin
            slow = s[i];
            wr(8'h4d, {3'h0, d[i]});
            fall(c);
            fall(c);
            fall(c);
            check(c, 2 * (d[i] == 0 ? 1 : d[i]) * (s[i] ? SLOW : FAST));
            check(pout, 1'b0);
        end
    endtask
    // One spin-up from a 0 to nonzero level: length and fan-on share
    task automatic spin_case(input logic [7:0] cfg, input int len, input int pct, input int tach_at);
        int n;
        int on;
        int p;
        n = 2;
        on = 0;
        wr(8'h4c, 8'h00);
        wr(8'h4b, cfg);
        wr(8'h4c, 8'h20);
        tick();
        if (len == 0) begin
            repeat (4) tick();
            check(spin, 1'b0);
            rd(8'h4c, 8'h20);
        end else begin
            rd(8'h4c, 8'h00);
            while (spin === 1'b1 && n < 9000) begin
                on += (fan_on === 1'b1);
                tach = (n >= tach_at);
                tick();
                n++;
            end
            tach = 1'b0;
            if (n >= 9000) begin
                fails++;
                wrap_up();
            end
            p = on * 100 / (n - 2);
            check(n >= len - 1 && n <= len + 3, 1'b1);
            check(p + 10 >= pct && p <= pct + 10, 1'b1);
        end
    endtask
    task automatic t_spin();
        spin_case(8'h09, UNIT, 50, 1000000);
        spin_case(8'h12, 2 * UNIT, 75, 1000000);
        spin_case(8'h1b, 4 * UNIT, 100, 1000000);
        spin_case(8'h22, 2 * UNIT, 100, 1000000);
        spin_case(8'h2a, 2 * UNIT, 100, 1000000);
        spin_case(8'h02, 0, 0, 1000000);
        spin_case(8'h38, 0, 0, 1000000);
        spin_case(8'h27, 300, 100, 300);
    endtask
    // Reset for 16 cycles, then the scenarios
    initial begin
        repeat (16) @(posedge clk);
        #2 rstn = 1'b1;
        tick();
        t_regs();
        t_period();
        t_spin();
        wrap_up();
    end
endmodule
